// File: hw/otfr_pkg.sv
package otfr_pkg;

    // Register map
    localparam logic [7:0] OTFR_CFG_ADDR   = 8'h50;
    localparam logic [7:0] OTFR_STAT_ADDR  = 8'h51;
    localparam logic [7:0] OTFR_CFG_RESET  = 8'h00;
    localparam logic [7:0] OTFR_RDATA_NONE = 8'h00;

    // Field positions of the configuration register
    localparam int OTFR_RESP_MSB  = 7;
    localparam int OTFR_RESP_LSB  = 6;
    localparam int OTFR_RETRY_MSB = 5;
    localparam int OTFR_RETRY_LSB = 3;
    localparam int OTFR_DLY_MSB   = 2;
    localparam int OTFR_DLY_LSB   = 0;

    // Retry code that means no limit
    localparam logic [2:0] OTFR_RETRY_INF = 3'h7;
    localparam logic [2:0] OTFR_RETRY_ONE = 3'h1;
    localparam logic [2:0] OTFR_RETRY_NONE = 3'h0;

    // Millisecond time base from the 100 MHz clock
    localparam int OTFR_MS_NS     = 1000000;
    localparam int OTFR_CLK_NS    = 10;
    localparam int OTFR_CYC_PER_MS = OTFR_MS_NS / OTFR_CLK_NS;
    localparam int OTFR_MS_W      = 12;

    // First delay: wait before the output is turned off, in ms
    localparam logic [11:0] OTFR_DLY1_MS [8] = '{
        12'h00A, 12'h014, 12'h028, 12'h050, 12'h0A0, 12'h140, 12'h280, 12'h500
    };
    // Second delay: spacing of restart attempts, in ms
    localparam logic [11:0] OTFR_DLY2_MS [8] = '{
        12'h0FC, 12'h22E, 12'h39C, 12'h4EC, 12'h63C, 12'h78C, 12'h8DC, 12'hA2C
    };

    typedef enum logic [1:0] {
        OTFR_RESP_IGNORE = 2'b00,
        OTFR_RESP_RIDE   = 2'b01,
        OTFR_RESP_SHUT   = 2'b10,
        OTFR_RESP_HOLD   = 2'b11
    } otfr_resp_t;

    typedef enum logic [2:0] {
        OTFR_ST_RUN   = 3'b000,
        OTFR_ST_RIDE  = 3'b001,
        OTFR_ST_OFF   = 3'b010,
        OTFR_ST_TRY   = 3'b011,
        OTFR_ST_HOLD  = 3'b100,
        OTFR_ST_LATCH = 3'b101
    } otfr_state_t;

    // Status word read back by the host
    typedef struct packed {
        otfr_state_t state;
        logic [2:0]  used;
        logic        latched;
        logic        out_en;
    } otfr_status_t;

endpackage : otfr_pkg

// File: hw/otfr_top.sv
`timescale 1ns/10ps
module otfr_top
    import otfr_pkg::*;
#(
    parameter int CYC_PER_MS = OTFR_CYC_PER_MS
) (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    // Register access port
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // Fault input from the threshold logic on this clock
    input  wire logic       fault_i,
    // Power stage control and status
    output logic            output_en_o,
    output logic            fault_latched_o
);

    localparam int PRE_W = $clog2(CYC_PER_MS + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_MS - 1);
    localparam logic [PRE_W-1:0] PRE_ZERO = '0;
    localparam logic [OTFR_MS_W-1:0] MS_ZERO = '0;
    localparam logic [OTFR_MS_W-1:0] MS_ONE  = OTFR_MS_W'(1);
    localparam logic [OTFR_MS_W-1:0] MS_FULL = '1;
    localparam logic [PRE_W-1:0]     PRE_ONE = PRE_W'(1);

    logic [7:0]           cfg;
    otfr_resp_t           resp;
    logic [2:0]           retry_code;
    logic [2:0]           dly_code;
    otfr_state_t          state;
    otfr_state_t          next_state;
    logic [2:0]           used;
    logic                 retry_avail;
    logic [PRE_W-1:0]     pre_cnt;
    logic [OTFR_MS_W-1:0] ms_cnt;
    logic                 tmr_clr;
    otfr_status_t         status;
    logic [OTFR_MS_W-1:0] dly1_ms;
    logic [OTFR_MS_W-1:0] dly2_ms;
    logic                 ms_tick;
    logic                 ms_full;
    logic                 ride_done;
    logic                 off_done;

    // Field decode of the configuration register
    assign resp       = otfr_resp_t'(cfg[OTFR_RESP_MSB:OTFR_RESP_LSB]);
    assign retry_code = cfg[OTFR_RETRY_MSB:OTFR_RETRY_LSB];
    assign dly_code   = cfg[OTFR_DLY_MSB:OTFR_DLY_LSB];

    // Another attempt is allowed while attempts remain or the count is unlimited
    assign retry_avail = (retry_code == OTFR_RETRY_INF) || (used < retry_code);

    // Both waits come from one delay code; the tables hold whole milliseconds
    assign dly1_ms = OTFR_DLY1_MS[dly_code];
    assign dly2_ms = OTFR_DLY2_MS[dly_code];

    // One tick per millisecond; the elapsed count stops at full scale
    assign ms_tick = (pre_cnt == PRE_LAST);
    assign ms_full = (ms_cnt == MS_FULL);

    // Wait ends use the live delay code, so a rewrite mid-wait moves the end point
    assign ride_done = (ms_cnt >= dly1_ms);
    assign off_done  = (ms_cnt >= dly2_ms);

    // Configuration register, written by the host at any time
    // The status word at the next address is read only; writes there are dropped
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg <= OTFR_CFG_RESET;
        end else if (reg_wr_i && reg_addr_i == OTFR_CFG_ADDR) begin
            cfg <= reg_wdata_i;
        end
    end

    // Read data is registered, so it appears one cycle after the address
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= OTFR_RDATA_NONE;
        end else if (reg_addr_i == OTFR_CFG_ADDR) begin
            reg_rdata_o <= cfg;
        end else if (reg_addr_i == OTFR_STAT_ADDR) begin
            reg_rdata_o <= status;
        end else begin
            reg_rdata_o <= OTFR_RDATA_NONE;
        end
    end

    // Status word for the host: state, attempts used, latch and enable
    assign status = '{state: state, used: used, latched: fault_latched_o, out_en: output_en_o};

    // Timer restarts on every state change, so each wait is measured from its own entry
    assign tmr_clr = (next_state != state);

    // Millisecond prescaler, restarted with the timer so every wait starts on a clean tick
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_cnt <= PRE_ZERO;
        end else if (tmr_clr || ms_tick) begin
            pre_cnt <= PRE_ZERO;
        end else begin
            pre_cnt <= pre_cnt + PRE_ONE;
        end
    end

    // Elapsed milliseconds in the current state; saturates so a very long wait cannot wrap
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ms_cnt <= MS_ZERO;
        end else if (tmr_clr) begin
            ms_cnt <= MS_ZERO;
        end else if (ms_tick && !ms_full) begin
            ms_cnt <= ms_cnt + MS_ONE;
        end
    end

    // Sequencer next state; the config is read live, so a rewrite takes effect at once
    always_comb begin
        next_state = state;
        unique case (state)
            // A fault seen in normal running starts the programmed reaction
            OTFR_ST_RUN: begin
                if (fault_i) begin
                    unique case (resp)
                        OTFR_RESP_IGNORE: next_state = OTFR_ST_RUN;
                        OTFR_RESP_RIDE:   next_state = OTFR_ST_RIDE;
                        OTFR_RESP_SHUT:   next_state = retry_avail ? OTFR_ST_OFF
                                                                   : OTFR_ST_LATCH;
                        OTFR_RESP_HOLD:   next_state = OTFR_ST_HOLD;
                    endcase
                end
            end
            OTFR_ST_RIDE: begin
                if (!fault_i || resp == OTFR_RESP_IGNORE) begin
                    next_state = OTFR_ST_RUN;
                end else if (ride_done) begin
                    next_state = retry_avail ? OTFR_ST_OFF : OTFR_ST_LATCH;
                end
            end
            // Output stays off for the whole restart spacing
            OTFR_ST_OFF: begin
                if (off_done) begin
                    next_state = OTFR_ST_TRY;
                end
            end
            // A rewrite to the ignore code abandons the sequence here as well
            OTFR_ST_TRY: begin
                if (!fault_i || resp == OTFR_RESP_IGNORE) begin
                    next_state = OTFR_ST_RUN;
                end else if (retry_avail) begin
                    next_state = OTFR_ST_OFF;
                end else begin
                    next_state = OTFR_ST_LATCH;
                end
            end
            // No timer here: the output returns as soon as the fault is gone
            OTFR_ST_HOLD: begin
                if (!fault_i) begin
                    next_state = OTFR_ST_RUN;
                end
            end
            // Left only through reset
            OTFR_ST_LATCH: begin
                next_state = OTFR_ST_LATCH;
            end
            default: begin
                next_state = OTFR_ST_LATCH;              // Illegal code fails safe, output off
            end
        endcase
    end

    // State register; only reset leaves the latched state
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= OTFR_ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Attempt counter: one more per restart, refilled on return to normal running
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            used <= OTFR_RETRY_NONE;
        end else if (next_state == OTFR_ST_RUN) begin
            used <= OTFR_RETRY_NONE;
        end else if (state == OTFR_ST_OFF && next_state == OTFR_ST_TRY
                     && used != OTFR_RETRY_INF) begin
            used <= used + OTFR_RETRY_ONE;
        end
    end

    // Output enable follows the next state, so it changes on the same edge as the state
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            output_en_o <= 1'b1;
        end else begin
            output_en_o <= (next_state == OTFR_ST_RUN) || (next_state == OTFR_ST_RIDE)
                           || (next_state == OTFR_ST_TRY);
        end
    end

    // Latched flag, also from the next state; reset is the only way to drop it
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_latched_o <= 1'b0;
        end else begin
            fault_latched_o <= (next_state == OTFR_ST_LATCH);
        end
    end

endmodule : otfr_top

// File: verif/otfr_checker_assertions.sv
`timescale 1ns/10ps
module otfr_checker
    import otfr_pkg::*;
(
    // Clock and reset
    input wire logic       clock_i,
    input wire logic       rst_n_i,
    // Register port, fault and power outputs
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       fault_i,
    input wire logic       output_en_o,
    input wire logic       fault_latched_o
);
    logic [7:0] cfg;
    logic [1:0] resp;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Shadow copy of the configuration, so checks follow mid-sequence rewrites
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) cfg <= OTFR_CFG_RESET;
        else if (reg_wr_i && reg_addr_i == OTFR_CFG_ADDR) cfg <= reg_wdata_i;
    end
    assign resp = cfg[OTFR_RESP_MSB:OTFR_RESP_LSB];
    AST_IGNORE: assert property (resp == 2'b00 && output_en_o |=> output_en_o)
        else $error("fault acted on while ignored");
    AST_RIDE: assert property ($rose(fault_i) && resp == 2'b01 && output_en_o |=> output_en_o [*8])
        else $error("output dropped before first delay");
    AST_SHUT: assert property (resp == 2'b10 && $rose(fault_i) |=> !output_en_o)
        else $error("output not shut at once");
    AST_HOLD: assert property (resp == 2'b11 && fault_i |=> !output_en_o)
        else $error("output not held off");
    AST_HOLD_REL: assert property (resp == 2'b11 && !fault_i && !output_en_o && !fault_latched_o |=> output_en_o)
        else $error("output not restored");
    AST_LATCH: assert property (fault_latched_o |=> fault_latched_o && !output_en_o)
        else $error("latched state left without reset");
    AST_RDATA: assert property (reg_addr_i == OTFR_CFG_ADDR && !reg_wr_i |=> reg_rdata_o == $past(cfg))
        else $error("config read back wrong");
    AST_UNMAP: assert property (reg_addr_i != OTFR_CFG_ADDR && reg_addr_i != OTFR_STAT_ADDR
        |=> reg_rdata_o == OTFR_RDATA_NONE) else $error("unmapped read not zero");
    COV_LATCH: cover property ($rose(fault_latched_o));
    COV_HOLD: cover property (resp == 2'b11 && $rose(output_en_o));
    COV_RIDE: cover property (resp == 2'b01 && $fell(output_en_o));
endmodule : otfr_checker

// File: verif/otfr_sensor_model.sv
`timescale 1ns/10ps
// Comparator model: the fault level changes only just after a clock edge, as same-domain logic would
module otfr_sensor_model (
    // Clock and requested temperature state
    input  wire logic clock_i,
    input  wire logic hot_i,
    // Fault level towards the sequencer
    output logic      fault_o = 1'b0
);
    always @(posedge clock_i) fault_o <= hot_i;
endmodule : otfr_sensor_model

// File: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    import otfr_pkg::*;
    logic       clock_i, rst_n_i, reg_wr_i, hot, fault_i, output_en_o, fault_latched_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    int         n_fail, checked, n;
    // Four cycles per ms keeps the 2.6 s delays short
    otfr_top #(.CYC_PER_MS(4)) i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .fault_i(fault_i),
        .output_en_o(output_en_o), .fault_latched_o(fault_latched_o));
    otfr_sensor_model i_sensor (.clock_i(clock_i), .hot_i(hot), .fault_o(fault_i));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        reg_addr_i <= a;
        @(posedge clock_i);
        #1 chk(reg_rdata_o, exp);
    endtask : rd
    task automatic idle(input int c);
        repeat (c) @(posedge clock_i);
        #1;
    endtask : idle
    task automatic set_hot(input logic v);
        @(posedge clock_i);
        hot <= v;
    endtask : set_hot
    // Bounded wait for the enable level; n returns the cycles taken
    task automatic wait_en(input logic v, input int lim);
        n = 0;
        while (output_en_o !== v && n < lim) begin
            @(posedge clock_i);
            #1 n++;
        end
        if (output_en_o !== v) begin
            n_fail++;
            $display("mismatch at %0t: enable wait ran out", $time);
            wrap_up();
        end
    endtask : wait_en
    initial begin
        {rst_n_i, reg_wr_i, hot, reg_addr_i, reg_wdata_i} = '0;
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(OTFR_CFG_ADDR, 8'h00);
        chk(output_en_o, 8'h01);
        wr(OTFR_CFG_ADDR, 8'h4A);
        rd(OTFR_CFG_ADDR, 8'h4A);
        wr(8'hA0, 8'hFF);
        rd(8'hA0, 8'h00);
        $display("register test done");
        wr(OTFR_CFG_ADDR, 8'h00);
        set_hot(1'b1);
        idle(50);
        chk(output_en_o, 8'h01);
        set_hot(1'b0);
        wr(OTFR_CFG_ADDR, 8'hC0);
        set_hot(1'b1);
        idle(3);
        chk(output_en_o, 8'h00);
        set_hot(1'b0);
        idle(3);
        chk(output_en_o, 8'h01);
        $display("ignore and hold tests done");
        // Ride through: 10 ms first delay, then 252 ms to the attempt
        wr(OTFR_CFG_ADDR, 8'h48);
        set_hot(1'b1);
        wait_en(1'b0, 100);
        chk(8'(n >= 38 && n <= 50), 8'h01);
        set_hot(1'b0);
        wait_en(1'b1, 1100);
        chk(8'(n >= 995 && n <= 1020), 8'h01);
        idle(3);
        chk(output_en_o, 8'h01);
        $display("ride test done");
        // Unlimited attempts never latch
        wr(OTFR_CFG_ADDR, 8'hB8);
        set_hot(1'b1);
        repeat (2) begin
            wait_en(1'b0, 10);
            wait_en(1'b1, 1100);
            idle(3);
            chk(fault_latched_o, 8'h00);
        end
        // One attempt with the fault still there ends latched
        wr(OTFR_CFG_ADDR, 8'h88);
        wait_en(1'b1, 1100);
        idle(3);
        chk({fault_latched_o, output_en_o}, 8'h02);
        set_hot(1'b0);
        idle(5);
        chk({fault_latched_o, output_en_o}, 8'h02);
        rd(OTFR_STAT_ADDR, 8'hAE);
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        idle(2);
        chk({fault_latched_o, output_en_o}, 8'h01);
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(OTFR_CFG_ADDR, 8'h00);
        $display("retry and latch tests done");
        // Fault gone inside the first delay: the output never drops
        wr(OTFR_CFG_ADDR, 8'h48);
        set_hot(1'b1);
        idle(20);
        set_hot(1'b0);
        idle(40);
        chk({fault_latched_o, output_en_o}, 8'h01);
        rd(OTFR_STAT_ADDR, 8'h01);
        // One good restart refills the single attempt for the next fault
        wr(OTFR_CFG_ADDR, 8'h88);
        set_hot(1'b1);
        wait_en(1'b0, 10);
        set_hot(1'b0);
        wait_en(1'b1, 1100);
        idle(3);
        chk(output_en_o, 8'h01);
        set_hot(1'b1);
        idle(5);
        chk({fault_latched_o, output_en_o}, 8'h00);
        // Shut with no attempts programmed latches at once
        set_hot(1'b0);
        wait_en(1'b1, 1100);
        wr(OTFR_CFG_ADDR, 8'h80);
        set_hot(1'b1);
        idle(3);
        chk({fault_latched_o, output_en_o}, 8'h02);
        $display("early clear and refill tests done");
        wrap_up();
    end
endmodule : testbench
bind otfr_top otfr_checker i_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .fault_i(fault_i),
    .output_en_o(output_en_o), .fault_latched_o(fault_latched_o));
